// *** rtl/fcr_pkg.sv ***
`default_nettype none
package fcr_pkg;
   // ==========================================================
   // Register map
   // ==========================================================
   localparam logic [15:0] FCR_ADDR_DIVIDER  = 16'h1820;
   localparam logic [15:0] FCR_ADDR_OPTIONS  = 16'h1821;
   localparam logic [15:0] FCR_ADDR_CONFIG   = 16'h1823;
   localparam logic [15:0] FCR_ADDR_PROTECT  = 16'h1824;
   localparam logic [15:0] FCR_ADDR_KEY_BASE = 16'hffb0;
   localparam logic [15:0] FCR_ADDR_FLASH_LO = 16'hf000;
   localparam int          FCR_KEY_BYTES     = 8;

   // ==========================================================
   // Field layout and reset values
   // ==========================================================
   localparam int          FCR_DIV_LOADED_BIT = 7;
   localparam int          FCR_DIV_PRESC_BIT  = 6;
   localparam int          FCR_OPT_BACKDOOR_KEY_ENABLE_BIT  = 7;
   localparam int          FCR_OPT_NORED_BIT  = 6;
   localparam int          FCR_CFG_KEY_WRITE_ACCESS_BIT = 5;
   localparam logic [7:0]  FCR_OPT_IMPL_MASK  = 8'hc3;
   localparam logic [1:0]  FCR_SEC_UNSECURED  = 2'h2;
   localparam logic [6:0]  FCR_DIV_RESET      = 7'h00;
   localparam logic [7:0]  FCR_BYTE_RESET     = 8'h00;

   // ==========================================================
   // Timing
   // ==========================================================
   localparam int FCR_REF_PERIOD_NS = 5;
   localparam int FCR_PULSE_MIN_NS  = 5000;
   localparam int FCR_PULSE_MAX_NS  = 6700;
   localparam int FCR_PULSE_MIN_CYC = (FCR_PULSE_MIN_NS + FCR_REF_PERIOD_NS - 1) /
                                      FCR_REF_PERIOD_NS;
   localparam int FCR_PULSE_MAX_CYC = FCR_PULSE_MAX_NS / FCR_REF_PERIOD_NS;
   localparam logic [2:0] FCR_PRESC_LAST = 3'h7;

   // ==========================================================
   // Carriers
   // ==========================================================
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
      logic        fromSecure;
      logic        fromDebug;
   } fcr_bus_req_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] addr;
      logic [7:0]  data;
   } fcr_flash_cmd_t;

   typedef enum logic [1:0] {
      CMP_IDLE,
      CMP_READ,
      CMP_CHECK
   } fcr_cmp_state_t;
endpackage
`default_nettype wire

// *** rtl/fcr_key_store.sv ***
`default_nettype none
module fcr_key_store #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8,
   parameter int AW    = 3
) (
   input  wire logic             ref_clk,
   input  wire logic             wrEn,
   input  wire logic [AW-1:0]    wrAddr,
   input  wire logic [WIDTH-1:0] wrData,
   input  wire logic [AW-1:0]    rdAddr,
   output logic      [WIDTH-1:0] rdData
);
   // ==========================================================
   // Storage
   // ==========================================================
   // Contents need no reset: each byte is written before it is compared.
   logic [WIDTH-1:0] mem [DEPTH];

   genvar e;
   generate
      for (e = 0; e < DEPTH; e++) begin : gEntry
         always_ff @(posedge ref_clk) begin
            if (wrEn && (wrAddr == AW'(e))) begin
               mem[e] <= wrData;
            end
         end
      end
   endgenerate

   always_ff @(posedge ref_clk) begin
      rdData <= mem[rdAddr];
   end
endmodule
`default_nettype wire

// *** rtl/fcr_flash_control_registers.sv ***
`default_nettype none
module fcr_flash_control_registers #(
   parameter int CNT_W = 8
) (
   input  wire logic                    ref_clk,
   input  wire logic                    reset,
   input  wire fcr_pkg::fcr_bus_req_t   busReq,
   output logic      [7:0]              busRdata,
   input  wire logic [7:0]              nvOptionsByte,
   input  wire logic [7:0]              nvProtectionByte,
   input  wire logic [63:0]             storedBackdoorKey,
   input  wire logic                    blankCheckPass,
   input  wire logic                    accessErrorClear,
   input  wire logic                    memAccessReq,
   input  wire logic                    memAccessFromSecure,
   input  wire logic                    memAccessFromDebug,
   input  wire logic                    pulseStart,
   input  wire logic [CNT_W-1:0]        pulseCount,
   output logic                         memAccessBlocked,
   output logic                         eraseProgramEnable,
   output logic                         flashClockTick,
   output logic                         timingInRange,
   output logic                         pulseActive,
   output fcr_pkg::fcr_flash_cmd_t      flashCmd,
   output logic                         accessErrorFlag,
   output logic                         secureState,
   output logic                         backdoorKeyEnable,
   output logic                         vectorRedirectDisable,
   output logic      [7:0]              workingProtection,
   output logic                         keyMatchDone
);
   // ==========================================================
   // Working registers
   // ==========================================================
   logic                   dividerLoaded_r;
   logic [6:0]             divider_r;
   logic [7:0]             options_r;
   logic                   keyWriteAccess_r;
   logic [7:0]             protection_r;
   logic                   accessError_r;

   logic                   wrDivider;
   logic                   wrConfig;
   logic                   inKeyRange;
   logic                   inFlash;
   logic                   keyWrite;
   logic                   cmdWrite;
   logic                   cmdAllowed;
   logic                   unlockTrigger;
   logic                   secure;

   logic [15:0]            keyOffset;

   assign wrDivider  = busReq.wr && (busReq.addr == fcr_pkg::FCR_ADDR_DIVIDER);
   assign wrConfig   = busReq.wr && (busReq.addr == fcr_pkg::FCR_ADDR_CONFIG);
   assign keyOffset  = busReq.addr - fcr_pkg::FCR_ADDR_KEY_BASE;
   assign inKeyRange = (busReq.addr >= fcr_pkg::FCR_ADDR_KEY_BASE) &&
                       (keyOffset < 16'(fcr_pkg::FCR_KEY_BYTES));
   assign inFlash    = busReq.addr >= fcr_pkg::FCR_ADDR_FLASH_LO;

   assign secure = options_r[1:0] != fcr_pkg::FCR_SEC_UNSECURED;

   // Debug writes are dropped here, so a debugger cannot probe the key.
   assign keyWrite = busReq.wr && inKeyRange && keyWriteAccess_r &&
                     busReq.fromSecure && !busReq.fromDebug;

   // Key locations only start a command while key access is off.
   assign cmdWrite = busReq.wr && inFlash && !(inKeyRange && keyWriteAccess_r);

   // Secure flash refuses writes from unsecured sources.
   assign cmdAllowed = !secure || (busReq.fromSecure && !busReq.fromDebug);

   assign unlockTrigger = wrConfig && keyWriteAccess_r &&
                          !busReq.wdata[fcr_pkg::FCR_CFG_KEY_WRITE_ACCESS_BIT];

   // ==========================================================
   // Clock divider register
   // ==========================================================
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         dividerLoaded_r <= 1'b0;
         divider_r       <= fcr_pkg::FCR_DIV_RESET;
      end else if (wrDivider && !dividerLoaded_r) begin
         dividerLoaded_r <= 1'b1;
         divider_r       <= busReq.wdata[6:0];
      end
   end

   assign eraseProgramEnable = dividerLoaded_r;

   // ==========================================================
   // Configuration register
   // ==========================================================
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         keyWriteAccess_r <= 1'b0;
      end else if (wrConfig) begin
         keyWriteAccess_r <= busReq.wdata[fcr_pkg::FCR_CFG_KEY_WRITE_ACCESS_BIT];
      end
   end

   // ==========================================================
   // Key sequence tracking
   // ==========================================================
   // Each byte must land at the next expected slot; any gap spoils the try.
   logic [3:0]             keyCount_r;
   logic                   keySeqOk_r;
   logic                   keyInOrder;

   assign keyInOrder = keyOffset[3:0] == keyCount_r;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         keyCount_r <= 4'h0;
         keySeqOk_r <= 1'b1;
      end else if (wrConfig) begin
         keyCount_r <= 4'h0;
         keySeqOk_r <= 1'b1;
      end else if (keyWrite) begin
         if (keyInOrder && (keyCount_r < 4'(fcr_pkg::FCR_KEY_BYTES))) begin
            keyCount_r <= keyCount_r + 4'h1;
         end else begin
            keySeqOk_r <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Key comparison
   // ==========================================================
   fcr_pkg::fcr_cmp_state_t cmpState_r;
   logic [2:0]             cmpIdx_r;
   logic                   cmpOk_r;
   logic [7:0]             enteredByte;
   logic [7:0]             storedByte;
   logic                   keyMatch;
   logic                   cmpStart;

   fcr_key_store #(
      .WIDTH (8),
      .DEPTH (fcr_pkg::FCR_KEY_BYTES),
      .AW    (3)
   ) uKeyStore (
      .ref_clk (ref_clk),
      .wrEn    (keyWrite && keyInOrder),
      .wrAddr  (keyOffset[2:0]),
      .wrData  (busReq.wdata),
      .rdAddr  (cmpIdx_r),
      .rdData  (enteredByte)
   );

   assign storedByte = storedBackdoorKey[{cmpIdx_r, 3'h0} +: 8];

   // A disabled backdoor never even starts the walk.
   assign cmpStart = unlockTrigger && options_r[fcr_pkg::FCR_OPT_BACKDOOR_KEY_ENABLE_BIT] &&
                     keySeqOk_r && (keyCount_r == 4'(fcr_pkg::FCR_KEY_BYTES));

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         cmpState_r <= fcr_pkg::CMP_IDLE;
         cmpIdx_r   <= 3'h0;
         cmpOk_r    <= 1'b1;
      end else begin
         case (cmpState_r)
            fcr_pkg::CMP_IDLE: begin
               cmpIdx_r <= 3'h0;
               cmpOk_r  <= 1'b1;
               if (cmpStart) begin
                  cmpState_r <= fcr_pkg::CMP_READ;
               end
            end
            fcr_pkg::CMP_READ: begin
               cmpState_r <= fcr_pkg::CMP_CHECK;
            end
            fcr_pkg::CMP_CHECK: begin
               cmpOk_r <= cmpOk_r && (enteredByte == storedByte);
               if (cmpIdx_r == 3'h7) begin
                  cmpState_r <= fcr_pkg::CMP_IDLE;
               end else begin
                  cmpIdx_r   <= cmpIdx_r + 3'h1;
                  cmpState_r <= fcr_pkg::CMP_READ;
               end
            end
            default: begin
               cmpState_r <= fcr_pkg::CMP_IDLE;
            end
         endcase
      end
   end

   assign keyMatch = (cmpState_r == fcr_pkg::CMP_CHECK) && (cmpIdx_r == 3'h7) &&
                     cmpOk_r && (enteredByte == storedByte);

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         keyMatchDone <= 1'b0;
      end else begin
         keyMatchDone <= (cmpState_r == fcr_pkg::CMP_CHECK) && (cmpIdx_r == 3'h7);
      end
   end

   // ==========================================================
   // Options and protection
   // ==========================================================
   // Bus writes never reach these; a reset reloads them, and only a key match or blank check changes options_r[1:0].
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         options_r <= nvOptionsByte & fcr_pkg::FCR_OPT_IMPL_MASK;
      end else if (keyMatch || blankCheckPass) begin
         options_r[1:0] <= fcr_pkg::FCR_SEC_UNSECURED;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         protection_r <= nvProtectionByte;
      end
   end

   assign backdoorKeyEnable     = options_r[fcr_pkg::FCR_OPT_BACKDOOR_KEY_ENABLE_BIT];
   assign vectorRedirectDisable = options_r[fcr_pkg::FCR_OPT_NORED_BIT];
   assign secureState           = secure;
   assign workingProtection     = protection_r;

   assign memAccessBlocked = memAccessReq && secure &&
                             (memAccessFromDebug || !memAccessFromSecure);

   // ==========================================================
   // Flash command launch and access error
   // ==========================================================
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         flashCmd <= '0;
      end else begin
         flashCmd.valid <= cmdWrite && cmdAllowed && dividerLoaded_r;
         flashCmd.addr  <= busReq.addr;
         flashCmd.data  <= busReq.wdata;
      end
   end

   // A new error in the clearing cycle survives the clear.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         accessError_r <= 1'b0;
      end else if (cmdWrite && cmdAllowed && !dividerLoaded_r) begin
         accessError_r <= 1'b1;
      end else if (accessErrorClear) begin
         accessError_r <= 1'b0;
      end
   end

   assign accessErrorFlag = accessError_r;

   // ==========================================================
   // Internal flash clock
   // ==========================================================
   logic [2:0]             prescCnt_r;
   logic [5:0]             divCnt_r;
   logic                   prescTick;
   logic [11:0]            periodCycles;

   assign prescTick = !divider_r[fcr_pkg::FCR_DIV_PRESC_BIT] ||
                      (prescCnt_r == fcr_pkg::FCR_PRESC_LAST);

   // The divider idles until it is loaded, so no tick runs at a stale rate.
   always_ff @(posedge ref_clk) begin
      if (reset || !dividerLoaded_r) begin
         prescCnt_r <= 3'h0;
         divCnt_r   <= 6'h00;
      end else begin
         prescCnt_r <= prescCnt_r + 3'h1;
         if (prescTick) begin
            if (divCnt_r == divider_r[5:0]) begin
               divCnt_r <= 6'h00;
            end else begin
               divCnt_r <= divCnt_r + 6'h01;
            end
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         flashClockTick <= 1'b0;
      end else begin
         flashClockTick <= dividerLoaded_r && prescTick &&
                           (divCnt_r == divider_r[5:0]);
      end
   end

   // Only a status aid; the choice of divider stays with software.
   assign periodCycles = (divider_r[fcr_pkg::FCR_DIV_PRESC_BIT] ? 12'h008 : 12'h001) *
                         ({6'h00, divider_r[5:0]} + 12'h001);
   assign timingInRange = dividerLoaded_r &&
                          (periodCycles >= 12'(fcr_pkg::FCR_PULSE_MIN_CYC)) &&
                          (periodCycles <= 12'(fcr_pkg::FCR_PULSE_MAX_CYC));

   // ==========================================================
   // Program and erase timing pulse
   // ==========================================================
   logic                   pulseArmed_r;
   logic [CNT_W-1:0]       pulseLeft_r;

   // The pulse starts and ends on ticks, so it spans whole periods.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pulseArmed_r <= 1'b0;
         pulseActive  <= 1'b0;
         pulseLeft_r  <= '0;
      end else if (pulseStart && !pulseArmed_r && !pulseActive && dividerLoaded_r) begin
         pulseArmed_r <= pulseCount != '0;
         pulseLeft_r  <= pulseCount;
      end else if (flashClockTick) begin
         if (pulseArmed_r) begin
            pulseArmed_r <= 1'b0;
            pulseActive  <= 1'b1;
         end else if (pulseActive) begin
            pulseLeft_r <= pulseLeft_r - CNT_W'(1);
            if (pulseLeft_r == CNT_W'(1)) begin
               pulseActive <= 1'b0;
            end
         end
      end
   end

   // ==========================================================
   // Register read
   // ==========================================================
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         busRdata <= fcr_pkg::FCR_BYTE_RESET;
      end else if (busReq.rd) begin
         case (busReq.addr)
            fcr_pkg::FCR_ADDR_DIVIDER: begin
               busRdata <= {dividerLoaded_r, divider_r};
            end
            fcr_pkg::FCR_ADDR_OPTIONS: begin
               busRdata <= options_r;
            end
            fcr_pkg::FCR_ADDR_CONFIG: begin
               busRdata <= {2'h0, keyWriteAccess_r, 5'h00};
            end
            fcr_pkg::FCR_ADDR_PROTECT: begin
               busRdata <= protection_r;
            end
            default: begin
               busRdata <= fcr_pkg::FCR_BYTE_RESET;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// *** verif/fcr_monitor.sv ***
`default_nettype none
// ==========================================================
// Port checker
// ==========================================================
module fcr_monitor (
   input wire logic                  ref_clk,
   input wire logic                  reset,
   input wire fcr_pkg::fcr_bus_req_t busReq,
   input wire logic [7:0]            busRdata,
   input wire logic                  blankCheckPass,
   input wire logic                  memAccessReq,
   input wire logic                  memAccessFromSecure,
   input wire logic                  memAccessFromDebug,
   input wire logic                  memAccessBlocked,
   input wire logic                  eraseProgramEnable,
   input wire logic                  flashClockTick,
   input wire logic                  pulseActive,
   input wire fcr_pkg::fcr_flash_cmd_t flashCmd,
   input wire logic                  accessErrorFlag,
   input wire logic                  secureState,
   input wire logic                  backdoorKeyEnable,
   input wire logic                  vectorRedirectDisable,
   input wire logic                  keyMatchDone
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   load_sticky_a: assert property (eraseProgramEnable |=> eraseProgramEnable)
      else $error("loaded flag dropped without reset");
   err_unloaded_a: assert property (busReq.wr && !eraseProgramEnable
      && busReq.addr >= fcr_pkg::FCR_ADDR_FLASH_LO
      && (!secureState || (busReq.fromSecure && !busReq.fromDebug))
      && (busReq.addr < 16'hffb0 || busReq.addr > 16'hffb7) |=> accessErrorFlag)
      else $error("early flash write did not raise access error");
   no_cmd_a: assert property (!eraseProgramEnable |=> !flashCmd.valid)
      else $error("flash command launched before divider write");
   mem_block_a: assert property (memAccessBlocked == (memAccessReq && secureState
      && (memAccessFromDebug || !memAccessFromSecure)))
      else $error("memory block decision wrong");
   opt_fixed_a: assert property (!$past(reset) |->
      $stable(backdoorKeyEnable) && $stable(vectorRedirectDisable))
      else $error("option bits changed outside reset");
   unsec_cause_a: assert property ($fell(secureState) |->
      keyMatchDone || blankCheckPass || $past(blankCheckPass))
      else $error("security left without key match or blank check");
   tick_gate_a: assert property (flashClockTick |-> eraseProgramEnable)
      else $error("flash clock runs before divider write");
   pulse_edge_a: assert property ($changed(pulseActive) |-> $past(flashClockTick))
      else $error("timing pulse edge off flash clock");
   rdata_hold_a: assert property (!$past(busReq.rd) |-> $stable(busRdata))
      else $error("read data moved without a read");
endmodule

bind fcr_flash_control_registers fcr_monitor i_mon (
   .ref_clk(ref_clk), .reset(reset), .busReq(busReq), .busRdata(busRdata),
   .blankCheckPass(blankCheckPass), .memAccessReq(memAccessReq),
   .memAccessFromSecure(memAccessFromSecure), .memAccessFromDebug(memAccessFromDebug),
   .memAccessBlocked(memAccessBlocked), .eraseProgramEnable(eraseProgramEnable),
   .flashClockTick(flashClockTick), .pulseActive(pulseActive), .flashCmd(flashCmd),
   .accessErrorFlag(accessErrorFlag), .secureState(secureState),
   .backdoorKeyEnable(backdoorKeyEnable), .vectorRedirectDisable(vectorRedirectDisable),
   .keyMatchDone(keyMatchDone)
);
`default_nettype wire

// *** verif/tb_top.sv ***
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
   $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // Stimulus and observation
   // ==========================================================
   localparam logic [63:0] KEY = 64'h0123456789abcdef;
   logic                    ref_clk, reset, blankCheckPass, accessErrorClear, pulseStart;
   logic                    memAccessReq, memAccessFromSecure, memAccessFromDebug;
   logic [7:0]              nonvolatile_options_byte, nonvolatile_protection_byte, busRdata, workingProtection, pulseCount;
   fcr_pkg::fcr_bus_req_t   busReq;
   fcr_pkg::fcr_flash_cmd_t flashCmd, lastCmd;
   logic                    memAccessBlocked, eraseProgramEnable, flashClockTick, timingInRange;
   logic                    pulseActive, accessErrorFlag, secureState, backdoorKeyEnable;
   logic                    vectorRedirectDisable, keyMatchDone;
   int                      fails, comparisons, cnt;

   fcr_flash_control_registers i_dut (
      .ref_clk(ref_clk), .reset(reset), .busReq(busReq), .busRdata(busRdata),
      .nvOptionsByte(nonvolatile_options_byte), .nvProtectionByte(nonvolatile_protection_byte), .storedBackdoorKey(KEY),
      .blankCheckPass(blankCheckPass), .accessErrorClear(accessErrorClear),
      .memAccessReq(memAccessReq), .memAccessFromSecure(memAccessFromSecure),
      .memAccessFromDebug(memAccessFromDebug), .pulseStart(pulseStart),
      .pulseCount(pulseCount), .memAccessBlocked(memAccessBlocked),
      .eraseProgramEnable(eraseProgramEnable), .flashClockTick(flashClockTick),
      .timingInRange(timingInRange), .pulseActive(pulseActive), .flashCmd(flashCmd),
      .accessErrorFlag(accessErrorFlag), .secureState(secureState),
      .backdoorKeyEnable(backdoorKeyEnable), .vectorRedirectDisable(vectorRedirectDisable),
      .workingProtection(workingProtection), .keyMatchDone(keyMatchDone));

   // ==========================================================
   // Bus tasks
   // ==========================================================
   // One idle cycle follows every write, since wr is dropped one cycle before the next request goes out.
   task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic dbg);
      @(negedge ref_clk);
      busReq = '{a, d, 1'b1, 1'b0, !dbg, dbg};
      @(negedge ref_clk);
      busReq.wr = 1'b0;
      lastCmd = flashCmd;
   endtask

   task automatic rdchk(input logic [15:0] a, input logic [7:0] e, input string n);
      @(negedge ref_clk);
      busReq = '{a, 8'h00, 1'b0, 1'b1, 1'b1, 1'b0};
      @(negedge ref_clk);
      busReq.rd = 1'b0;
      `CHK(n, e, busRdata)
   endtask

   task automatic sendKey(input logic [63:0] k, input logic dbg);
      wr(fcr_pkg::FCR_ADDR_CONFIG, 8'h20, 1'b0);
      for (int i = 0; i < 8; i++) begin
         wr(fcr_pkg::FCR_ADDR_KEY_BASE + 16'(i), k[8*i+:8], dbg);
      end
      wr(fcr_pkg::FCR_ADDR_CONFIG, 8'h00, 1'b0);
      for (cnt = 0; cnt < 30 && keyMatchDone !== 1'b1; cnt++) @(negedge ref_clk);
   endtask

   task automatic doReset(input logic [7:0] opt);
      @(negedge ref_clk);
      reset = 1'b1;
      nonvolatile_options_byte = opt;
      repeat (4) @(negedge ref_clk);
      reset = 1'b0;
   endtask

   task automatic final_report;
      if (fails == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   // The whole sequence takes a few hundred cycles.
   initial begin
      #50us;
      fails++;
      final_report();
   end

   // ==========================================================
   // Tests
   // ==========================================================
   initial begin
      busReq = '0;
      reset = 1'b1;
      {blankCheckPass, accessErrorClear, pulseStart, pulseCount} = '0;
      {memAccessReq, memAccessFromSecure, memAccessFromDebug} = 3'b101;
      nonvolatile_protection_byte = 8'h5a;
      doReset(8'hff);
      `CHK("wprot", 8'h5a, workingProtection)
      rdchk(fcr_pkg::FCR_ADDR_DIVIDER, 8'h00, "divider");
      rdchk(fcr_pkg::FCR_ADDR_OPTIONS, 8'hc3, "options");
      rdchk(fcr_pkg::FCR_ADDR_PROTECT, 8'h5a, "protection");
      rdchk(16'h1822, 8'h00, "unmapped");
      `CHK("secure", 1'b1, secureState)
      `CHK("redirect", 1'b1, vectorRedirectDisable)
      `CHK("blocked", 1'b1, memAccessBlocked)
      wr(16'hf100, 8'h5a, 1'b0);
      `CHK("early cmd", 1'b0, lastCmd.valid)
      `CHK("acc err", 1'b1, accessErrorFlag)
      @(negedge ref_clk) accessErrorClear = 1'b1;
      @(negedge ref_clk) accessErrorClear = 1'b0;
      `CHK("acc err clr", 1'b0, accessErrorFlag)
      wr(fcr_pkg::FCR_ADDR_DIVIDER, 8'h43, 1'b0);
      `CHK("in range", 1'b0, timingInRange)
      rdchk(fcr_pkg::FCR_ADDR_DIVIDER, 8'hc3, "divider");
      wr(fcr_pkg::FCR_ADDR_DIVIDER, 8'h01, 1'b0);
      rdchk(fcr_pkg::FCR_ADDR_DIVIDER, 8'hc3, "divider");
      `CHK("ep enable", 1'b1, eraseProgramEnable)
      for (cnt = 0; cnt < 100 && flashClockTick !== 1'b1; cnt++) @(negedge ref_clk);
      @(negedge ref_clk);
      for (cnt = 1; cnt < 100 && flashClockTick !== 1'b1; cnt++) @(negedge ref_clk);
      `CHK("tick period", 32, cnt)
      @(negedge ref_clk) {pulseStart, pulseCount} = {1'b1, 8'h02};
      @(negedge ref_clk) pulseStart = 1'b0;
      for (cnt = 0; cnt < 100 && pulseActive !== 1'b1; cnt++) @(negedge ref_clk);
      for (cnt = 0; cnt < 200 && pulseActive === 1'b1; cnt++) @(negedge ref_clk);
      `CHK("pulse len", 64, cnt)
      wr(16'hffb3, 8'ha5, 1'b0);
      `CHK("key cmd", {1'b1, 16'hffb3, 8'ha5}, lastCmd)
      wr(16'hf200, 8'h11, 1'b1);
      `CHK("dbg cmd", 1'b0, lastCmd.valid)
      wr(fcr_pkg::FCR_ADDR_OPTIONS, 8'h00, 1'b0);
      rdchk(fcr_pkg::FCR_ADDR_OPTIONS, 8'hc3, "options");
      wr(fcr_pkg::FCR_ADDR_CONFIG, 8'hff, 1'b0);
      rdchk(fcr_pkg::FCR_ADDR_CONFIG, 8'h20, "config");
      sendKey(KEY, 1'b1);
      `CHK("debug key", 1'b1, secureState)
      sendKey(KEY ^ 64'h1, 1'b0);
      `CHK("bad key", 1'b1, secureState)
      sendKey(KEY, 1'b0);
      `CHK("match done", 1'b1, keyMatchDone)
      `CHK("unlocked", 1'b0, secureState)
      `CHK("unblocked", 1'b0, memAccessBlocked)
      rdchk(fcr_pkg::FCR_ADDR_OPTIONS, 8'hc2, "options");
      doReset(8'h43);
      rdchk(fcr_pkg::FCR_ADDR_DIVIDER, 8'h00, "divider");
      rdchk(fcr_pkg::FCR_ADDR_OPTIONS, 8'h43, "options");
      `CHK("key enable", 1'b0, backdoorKeyEnable)
      sendKey(KEY, 1'b0);
      `CHK("key off", 1'b1, secureState)
      @(negedge ref_clk) blankCheckPass = 1'b1;
      @(negedge ref_clk) blankCheckPass = 1'b0;
      @(negedge ref_clk);
      `CHK("blank unsec", 1'b0, secureState)
      final_report();
   end
endmodule
`default_nettype wire
